// ===== common/dcw_pkg.sv
// Constants for the disk controller command and status word block
package dcw_pkg;
	// ****************************************
	// Command word fields
	// ****************************************
	localparam int HEAD_CODE_LSB = 0;
	localparam int HEAD_CODE_W = 4;
	localparam int RETURN_TO_ZERO_BIT = 6;
	localparam int CYL_MARK_BIT = 13;
	localparam int HEAD_MARK_BIT = 14;
	localparam int CTRL_MARK_BIT = 15;
	localparam logic [3:0] HEAD_COUNT = 4'he;
	// ****************************************
	// Address word fields
	// ****************************************
	localparam int SECT_LSB = 0;
	localparam int SECT_W = 6;
	localparam int AHEAD_BIT = 6;
	localparam int CYL_LSB = 7;
	localparam int CYL_W = 9;
	localparam logic [5:0] SECT_COUNT = 6'h28;
	// ****************************************
	// Error words
	// ****************************************
	localparam int EPOS_W = 13;
	localparam int EPAT_W = 11;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [3:0] OFF_CMD = 4'h0;
	localparam logic [3:0] OFF_ADDR = 4'h1;
	localparam logic [3:0] OFF_CSTAT = 4'h2;
	localparam logic [3:0] OFF_CUR = 4'h3;
	localparam logic [3:0] OFF_CART0 = 4'h4;
	localparam logic [3:0] OFF_CART1 = 4'h5;
	localparam logic [3:0] OFF_FIX0 = 4'h6;
	localparam logic [3:0] OFF_FIX1 = 4'h7;
	localparam logic [3:0] OFF_EPOS = 4'h8;
	localparam logic [3:0] OFF_EPAT = 4'h9;
	// ****************************************
	// Status word layout
	// ****************************************
	localparam int ST_DONE_BIT = 16;
	localparam int ST_OK_BIT = 17;
	localparam int ST_TMO_BIT = 18;
	localparam int ST_CHG_BIT = 19;
	localparam int ST_FLT_LSB = 20;
	localparam int ST_FLT_W = 3;
	localparam int ST_IRQ_BIT = 23;
	localparam int ST_BUSY_BIT = 24;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 10000000;
	localparam int TIMEOUT_MS = 150;
	localparam longint TIMEOUT_CYC = longint'(CLK_HZ) * TIMEOUT_MS / 1000;
	typedef enum logic [1:0] {
		DCW_IDLE = 2'b00,
		DCW_RUN = 2'b01,
		DCW_DONE = 2'b10
	} dcw_state_t;
endpackage

// ===== hdl/dcw_timer.sv
// Function time limit counter
`timescale 1ns/100ps
module dcw_timer #(
	parameter int W = 21
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Control
	input wire logic start,
	input wire logic stop,
	input wire logic [W-1:0] limit,
	// Result
	output logic expired
);
	logic [W-1:0] cnt_q;
	logic run_q;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			expired <= 1'b0;
		end else if (start) begin
			cnt_q <= '0;
			run_q <= 1'b1;
			expired <= 1'b0;
		end else if (stop) begin
			run_q <= 1'b0;
			expired <= 1'b0;
		end else if (run_q) begin
			cnt_q <= cnt_q + 1'b1;
			expired <= (cnt_q + 1'b1 >= limit);
			if (cnt_q + 1'b1 >= limit) begin
				run_q <= 1'b0;
			end
		end else begin
			expired <= 1'b0;
		end
	end
endmodule

// ===== hdl/dcw_core.sv
// Command interpreter and status word generator of the disk controller
// ****************************************
// ****************************************
`timescale 1ns/100ps
module dcw_core #(
	parameter longint TIMEOUT_CYCLES = dcw_pkg::TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Drive side events
	input wire logic xfer_done,
	input wire logic [15:0] last_addr,
	input wire logic func_done,
	input wire logic func_ok,
	input wire logic drive_change,
	input wire logic [2:0] fault_type,
	input wire logic [15:0] cart_status,
	input wire logic [15:0] fixed_status,
	input wire logic read_error,
	input wire logic [12:0] err_position,
	input wire logic [10:0] err_pattern,
	// Drive commands
	output logic recal_pulse,
	output logic head_sel_pulse,
	output logic [3:0] head_code,
	output logic xfer_start,
	output logic [15:0] start_addr,
	// Interrupt request to the system bus
	output logic slow_interrupt_request
);
	localparam int TW = 32;
	dcw_pkg::dcw_state_t state_q;
	logic [15:0] ctrl_q;
	logic [15:0] cur_addr_q;
	logic done_q, ok_q, tmo_q, chg_q;
	logic [2:0] flt_q;
	logic [12:0] epos_q;
	logic [10:0] epat_q;
	logic expired;
	logic cmd_wr, is_head, is_recal, is_ctrl;

	// ****************************************
	// Command decode
	// ****************************************
	assign cmd_wr = wr && addr == dcw_pkg::OFF_CMD;
	assign is_head = wdata[dcw_pkg::HEAD_MARK_BIT] && !wdata[dcw_pkg::CYL_MARK_BIT]
		&& !wdata[dcw_pkg::CTRL_MARK_BIT];
	assign is_ctrl = wdata[dcw_pkg::CTRL_MARK_BIT] && !wdata[dcw_pkg::CYL_MARK_BIT]
		&& !wdata[dcw_pkg::HEAD_MARK_BIT];
	assign is_recal = is_ctrl && wdata[dcw_pkg::RETURN_TO_ZERO_BIT];

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			recal_pulse <= 1'b0;
			head_sel_pulse <= 1'b0;
			head_code <= 4'h0;
		end else begin
			recal_pulse <= cmd_wr && is_recal;
			head_sel_pulse <= cmd_wr && is_head && wdata[3:0] < dcw_pkg::HEAD_COUNT;
			if (cmd_wr && is_head) begin
				head_code <= wdata[dcw_pkg::HEAD_CODE_LSB +: dcw_pkg::HEAD_CODE_W];
			end
		end
	end

	// Last command word of any kind kept for the status echo
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= 16'h0000;
		end else if (cmd_wr) begin
			ctrl_q <= wdata[15:0];
		end
	end

	// ****************************************
	// Address words
	// ****************************************
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			start_addr <= 16'h0000;
			xfer_start <= 1'b0;
		end else begin
			xfer_start <= wr && addr == dcw_pkg::OFF_ADDR
				&& wdata[dcw_pkg::SECT_LSB +: dcw_pkg::SECT_W] < dcw_pkg::SECT_COUNT;
			if (wr && addr == dcw_pkg::OFF_ADDR) begin
				start_addr <= wdata[15:0];
			end
		end
	end

	// Same layout as the address word, so the drive's last address is kept unchanged
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cur_addr_q <= 16'h0000;
		end else if (xfer_done) begin
			cur_addr_q <= last_addr;
		end
	end

	// ****************************************
	// Function sequencing and time limit
	// ****************************************
	dcw_timer #(.W(TW)) u_timer (
		.clock(clock),
		.reset_n(reset_n),
		.start(cmd_wr),
		.stop(func_done),
		.limit(TW'(TIMEOUT_CYCLES)),
		.expired(expired)
	);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= dcw_pkg::DCW_IDLE;
			done_q <= 1'b0;
			ok_q <= 1'b0;
			tmo_q <= 1'b0;
		end else begin
			case (state_q)
				dcw_pkg::DCW_IDLE, dcw_pkg::DCW_DONE: begin
					if (cmd_wr) begin
						state_q <= dcw_pkg::DCW_RUN;
						done_q <= 1'b0;
						ok_q <= 1'b0;
						tmo_q <= 1'b0;
					end
				end
				dcw_pkg::DCW_RUN: begin
					if (cmd_wr) begin
						ok_q <= 1'b0;
					end else if (func_done) begin
						state_q <= dcw_pkg::DCW_DONE;
						done_q <= 1'b1;
						ok_q <= func_ok;
					end else if (expired) begin
						state_q <= dcw_pkg::DCW_DONE;
						done_q <= 1'b1;
						tmo_q <= 1'b1;
					end
				end
				default: state_q <= dcw_pkg::DCW_IDLE;
			endcase
		end
	end

	// Drive change is sticky; set wins over a clearing status read
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			chg_q <= 1'b0;
			flt_q <= 3'h0;
		end else begin
			if (drive_change) begin
				chg_q <= 1'b1;
			end else if (rd && addr == dcw_pkg::OFF_CSTAT) begin
				chg_q <= 1'b0;
			end
			if (fault_type != 3'h0) begin
				flt_q <= fault_type;
			end else if (cmd_wr) begin
				flt_q <= 3'h0;
			end
		end
	end

	// Slow request raised on completion or drive change, dropped on status read
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			slow_interrupt_request <= 1'b0;
		end else if ((state_q == dcw_pkg::DCW_RUN && (func_done || expired)) || drive_change) begin
			slow_interrupt_request <= 1'b1;
		end else if (rd && addr == dcw_pkg::OFF_CSTAT) begin
			slow_interrupt_request <= 1'b0;
		end
	end

	// ****************************************
	// Error words
	// ****************************************
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			epos_q <= 13'h0000;
			epat_q <= 11'h000;
		end else if (read_error) begin
			epos_q <= err_position;
			epat_q <= err_pattern;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= 32'h00000000;
		end else if (rd) begin
			case (addr)
				dcw_pkg::OFF_CMD: rdata <= {16'h0000, ctrl_q};
				dcw_pkg::OFF_ADDR: rdata <= {16'h0000, start_addr};
				dcw_pkg::OFF_CSTAT: begin
					rdata <= {7'h00, state_q == dcw_pkg::DCW_RUN, slow_interrupt_request,
						flt_q, chg_q, tmo_q, ok_q, done_q, ctrl_q};
				end
				dcw_pkg::OFF_CUR: rdata <= {16'h0000, cur_addr_q};
				dcw_pkg::OFF_CART0: rdata <= {24'h000000, cart_status[7:0]};
				dcw_pkg::OFF_CART1: rdata <= {24'h000000, cart_status[15:8]};
				dcw_pkg::OFF_FIX0: rdata <= {24'h000000, fixed_status[7:0]};
				dcw_pkg::OFF_FIX1: rdata <= {24'h000000, fixed_status[15:8]};
				dcw_pkg::OFF_EPOS: rdata <= {19'h00000, epos_q};
				dcw_pkg::OFF_EPAT: rdata <= {19'h00000, 2'b00, epat_q};
				default: rdata <= 32'h00000000;
			endcase
		end else begin
			rdata <= 32'h00000000;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_recal;
		@(posedge clock) disable iff (!reset_n)
		(wr && addr == dcw_pkg::OFF_CMD && wdata[15] && wdata[6] && !wdata[14] && !wdata[13])
		|=> recal_pulse;
	endproperty
	a_recal: assert property (p_recal) else $error("recal not issued");

	property p_head;
		@(posedge clock) disable iff (!reset_n)
		(wr && addr == dcw_pkg::OFF_CMD && wdata[14] && !wdata[13] && !wdata[15])
		|=> head_code == $past(wdata[3:0]);
	endproperty
	a_head: assert property (p_head) else $error("head code wrong");

	property p_headmark;
		@(posedge clock) disable iff (!reset_n)
		head_sel_pulse |-> $past(wdata[14]);
	endproperty
	a_headmark: assert property (p_headmark) else $error("head select without mark");

	property p_echo;
		@(posedge clock) disable iff (!reset_n)
		(wr && addr == dcw_pkg::OFF_CMD) ##1 (rd && addr == dcw_pkg::OFF_CSTAT && !wr)
		|=> rdata[15:0] == $past(wdata[15:0], 2);
	endproperty
	a_echo: assert property (p_echo) else $error("status echo wrong");

	property p_cur;
		@(posedge clock) disable iff (!reset_n)
		xfer_done ##1 (rd && addr == dcw_pkg::OFF_CUR && !xfer_done)
		|=> rdata == {16'h0000, $past(last_addr, 2)};
	endproperty
	a_cur: assert property (p_cur) else $error("current address wrong");

	property p_epat;
		@(posedge clock) disable iff (!reset_n)
		$past(rd) && $past(addr) == dcw_pkg::OFF_EPAT |-> rdata[31:11] == 21'h000000;
	endproperty
	a_epat: assert property (p_epat) else $error("pattern high bits set");

	property p_epos;
		@(posedge clock) disable iff (!reset_n)
		$past(rd) && $past(addr) == dcw_pkg::OFF_EPOS |-> rdata[31:13] == 19'h00000;
	endproperty
	a_epos: assert property (p_epos) else $error("position too wide");

	property p_cart;
		@(posedge clock) disable iff (!reset_n)
		(rd && addr == dcw_pkg::OFF_CART1) |=> rdata == {24'h000000, $past(cart_status[15:8])};
	endproperty
	a_cart: assert property (p_cart) else $error("cartridge byte wrong");

	property p_tmo;
		@(posedge clock) disable iff (!reset_n)
		(state_q == dcw_pkg::DCW_RUN && expired && !func_done && !cmd_wr)
		|=> tmo_q && done_q && slow_interrupt_request;
	endproperty
	a_tmo: assert property (p_tmo) else $error("timeout not flagged");

	property p_ok;
		@(posedge clock) disable iff (!reset_n)
		(state_q == dcw_pkg::DCW_RUN && func_done && !cmd_wr) |=> ok_q == $past(func_ok);
	endproperty
	a_ok: assert property (p_ok) else $error("success flag wrong");

	property p_recal_src;
		@(posedge clock) disable iff (!reset_n)
		recal_pulse |-> $past(wr) && $past(addr) == dcw_pkg::OFF_CMD
			&& $past(wdata[15]) && $past(wdata[6]);
	endproperty
	a_recal_src: assert property (p_recal_src) else $error("recal without command");

	property p_xfer;
		@(posedge clock) disable iff (!reset_n)
		(wr && addr == dcw_pkg::OFF_ADDR && wdata[5:0] < dcw_pkg::SECT_COUNT)
		|=> xfer_start && start_addr == $past(wdata[15:0]);
	endproperty
	a_xfer: assert property (p_xfer) else $error("transfer start missing");

	property p_chg;
		@(posedge clock) disable iff (!reset_n)
		drive_change |=> chg_q && slow_interrupt_request;
	endproperty
	a_chg: assert property (p_chg) else $error("drive change lost");

	property p_errcap;
		@(posedge clock) disable iff (!reset_n)
		read_error |=> epos_q == $past(err_position) && epat_q == $past(err_pattern);
	endproperty
	a_errcap: assert property (p_errcap) else $error("error words not captured");

	c_recal: cover property (@(posedge clock) disable iff (!reset_n) recal_pulse);
	c_tmo: cover property (@(posedge clock) disable iff (!reset_n) tmo_q);
	c_done: cover property (@(posedge clock) disable iff (!reset_n) done_q && ok_q);
	c_err: cover property (@(posedge clock) disable iff (!reset_n) read_error);
endmodule

// ===== bench/dcw_drive_model.sv
// Behavioural drive side answering the controller's commands
`timescale 1ns/100ps
module dcw_drive_model (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Commands from the controller
	input wire logic recal_pulse,
	input wire logic head_sel_pulse,
	input wire logic xfer_start,
	input wire logic [15:0] start_addr,
	// Test knobs: hung drive, answer latency
	input wire logic hang,
	input wire logic [7:0] lat,
	// Answers
	output logic func_done,
	output logic func_ok,
	output logic xfer_done,
	output logic [15:0] last_addr
);
	int fcnt;
	int xcnt;
	// A hung drive never answers a recalibrate or head select, so only the time limit ends the function
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fcnt <= 0;
			xcnt <= 0;
			func_done <= 1'b0;
			func_ok <= 1'b0;
			xfer_done <= 1'b0;
			last_addr <= 16'h0000;
		end else begin
			if ((recal_pulse || head_sel_pulse) && !hang) begin
				fcnt <= int'(lat);
			end else if (fcnt != 0) begin
				fcnt <= fcnt - 1;
			end
			if (xfer_start) begin
				xcnt <= int'(lat);
			end else if (xcnt != 0) begin
				xcnt <= xcnt - 1;
			end
			func_done <= (fcnt == 1);
			// Level is only meaningful beside the done pulse
			func_ok <= (fcnt == 1) ? 1'b1 : ~func_ok;
			xfer_done <= (xcnt == 1);
			// Ran on to the last sector of the track
			last_addr <= (xcnt == 1) ? {start_addr[15:6], 6'h27} : ~last_addr;
		end
	end
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the command and status word block
`timescale 1ns/100ps
module testbench;
	logic clock;
	logic reset_n;
	logic [3:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	logic xfer_done, func_done, func_ok, drive_change, read_error, hang;
	logic [15:0] last_addr, cart_status, fixed_status, start_addr;
	logic [2:0] fault_type;
	logic [12:0] err_position;
	logic [10:0] err_pattern;
	logic recal_pulse, head_sel_pulse, xfer_start, slow_interrupt_request;
	logic [3:0] head_code;
	logic [7:0] lat;
	logic [2:0] p;
	logic [31:0] d;
	int error_cnt = 0;
	int n_checks = 0;
	int i;
	// ****************************************
	// Design and drive model
	// ****************************************
	dcw_core #(.TIMEOUT_CYCLES(20)) i_dut (.clock(clock), .reset_n(reset_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .xfer_done(xfer_done),
		.last_addr(last_addr), .func_done(func_done), .func_ok(func_ok),
		.drive_change(drive_change), .fault_type(fault_type), .cart_status(cart_status),
		.fixed_status(fixed_status), .read_error(read_error), .err_position(err_position),
		.err_pattern(err_pattern), .recal_pulse(recal_pulse), .head_sel_pulse(head_sel_pulse),
		.head_code(head_code), .xfer_start(xfer_start), .start_addr(start_addr),
		.slow_interrupt_request(slow_interrupt_request));
	dcw_drive_model i_drive (.clock(clock), .reset_n(reset_n), .recal_pulse(recal_pulse),
		.head_sel_pulse(head_sel_pulse), .xfer_start(xfer_start), .start_addr(start_addr),
		.hang(hang), .lat(lat), .func_done(func_done), .func_ok(func_ok),
		.xfer_done(xfer_done), .last_addr(last_addr));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
		n_checks++;
		if ((g & m) !== (e & m)) begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Pulses are caught in the cycle after the write
	task automatic wr_w(input logic [3:0] a, input logic [31:0] w, output logic [2:0] q);
		@(posedge clock);
		addr <= a;
		wdata <= w;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		#1 q = {recal_pulse, head_sel_pulse, xfer_start};
	endtask
	task automatic rd_r(input logic [3:0] a, output logic [31:0] q);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 q = rdata;
	endtask
	task automatic wait_sig(input bit irq);
		for (i = 0; i < 100 && (irq ? slow_interrupt_request : xfer_done) !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		if (i == 100) begin
			error_cnt++;
			$display("[FAIL] %0t wait ran out", $time);
			stop_test;
		end
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		reset_n = 1'b0;
		{addr, wdata, wr, rd, drive_change, fault_type, read_error, hang} = '0;
		{err_position, err_pattern} = '0;
		cart_status = 16'ha55a;
		fixed_status = 16'h3cc3;
		lat = 8'h03;
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		// Recalibrate answered promptly, then slowly but inside the limit
		repeat (2) begin
			wr_w(dcw_pkg::OFF_CMD, 32'h8040, p);
			chk(p, 32'h4, 32'h7);
			wait_sig(1'b1);
			rd_r(dcw_pkg::OFF_CSTAT, d);
			chk(d, 32'h00838040, 32'h0087ffff);
			chk(slow_interrupt_request, 32'h0, 32'h1);
			lat = 8'h0c;
		end
		lat = 8'h03;
		$display("test recalibrate done");
		// Hung drive, then a recalibrate word with the head marker set
		hang <= 1'b1;
		// Command write and status read back to back
		@(posedge clock);
		addr <= dcw_pkg::OFF_CMD;
		wdata <= 32'h8040;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		rd <= 1'b1;
		addr <= dcw_pkg::OFF_CSTAT;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
		chk(d, 32'h00008040, 32'h0004ffff);
		repeat (25) @(posedge clock);
		rd_r(dcw_pkg::OFF_CSTAT, d);
		chk(d, 32'h00048040, 32'h0004ffff);
		hang <= 1'b0;
		wr_w(dcw_pkg::OFF_CMD, 32'hc040, p);
		chk(p, 32'h0, 32'h7);
		repeat (25) @(posedge clock);
		rd_r(dcw_pkg::OFF_CSTAT, d);
		chk(d, 32'h0004c040, 32'h0004ffff);
		$display("test timeout done");
		// Every head code, with both other markers clear
		for (int c = 0; c < 16; c++) begin
			wr_w(dcw_pkg::OFF_CMD, 32'h4000 | c, p);
			chk(p, (c < 14) ? 32'h2 : 32'h0, 32'h7);
			if (c < 14) chk(head_code, c, 32'hf);
		end
		$display("test head select done");
		// Address words: a legal sector, then one past the last legal one
		wr_w(dcw_pkg::OFF_ADDR, 32'hffc5, p);
		chk(p, 32'h1, 32'h7);
		chk(start_addr, 32'hffc5, 32'hffff);
		wait_sig(1'b0);
		rd_r(dcw_pkg::OFF_CUR, d);
		chk(d, 32'hffe7, 32'hffffffff);
		wr_w(dcw_pkg::OFF_ADDR, 32'h0028, p);
		chk(p, 32'h0, 32'h1);
		$display("test address done");
		// Drive status bytes, low byte first
		for (int k = 0; k < 4; k++) begin
			rd_r(dcw_pkg::OFF_CART0 + 4'(k), d);
			chk(d, (32'h3cc3a55a >> (8 * k)) & 32'hff, 32'hffffffff);
		end
		$display("test drive status done");
		// Error words; inputs move on after capture
		@(posedge clock);
		read_error <= 1'b1;
		err_position <= 13'h1abc;
		err_pattern <= 11'h5a3;
		@(posedge clock);
		read_error <= 1'b0;
		err_position <= 13'h0543;
		err_pattern <= 11'h25c;
		rd_r(dcw_pkg::OFF_EPOS, d);
		chk(d, 32'h1abc, 32'hffffffff);
		rd_r(dcw_pkg::OFF_EPAT, d);
		chk(d, 32'h05a3, 32'hffffffff);
		$display("test error words done");
		// Drive change and fault code, change cleared by the read
		@(posedge clock);
		drive_change <= 1'b1;
		fault_type <= 3'h5;
		@(posedge clock);
		drive_change <= 1'b0;
		fault_type <= 3'h0;
		rd_r(dcw_pkg::OFF_CSTAT, d);
		chk(d, 32'h00580000, 32'h00780000);
		rd_r(dcw_pkg::OFF_CSTAT, d);
		chk(d, 32'h0, 32'h00080000);
		rd_r(4'hf, d);
		chk(d, 32'h0, 32'hffffffff);
		$display("test fault and unmapped done");
		stop_test;
	end
endmodule
